// >>> verilog/spp_map.vh
// Constants for the serial peripheral port: widths, depths and timing
`ifndef SPP_MAP_VH
`define SPP_MAP_VH
`define SPP_WORD_BITS   8
`define SPP_FIFO_DEPTH  4
`define SPP_DIV_DEFAULT 4
`define SPP_CNT_BITS    4
`endif

// >>> verilog/spp_port.v
// Serial peripheral port with master and slave modes and a transmit FIFO
// Summary of operation
// - Port runs as master or slave.
// - Slave shifts only while select asserted.
// - Select pin is always an input.
// - Select asserted during master mode flags error.
// - Master never drives select; software GPIO does.
// - Shift clock toggles only during transfers.
// - All four polarity/phase combinations selectable.
// - Master drives clock, out on MOSI, in MISO.
// - Slave uses external clock, in MOSI, out MISO.
`timescale 1ns/1ps
`include "spp_map.vh"

module spp_fifo #(
    parameter WIDTH = `SPP_WORD_BITS,
    parameter DEPTH = `SPP_FIFO_DEPTH,
    parameter AW    = 2
) (
    // Clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // Fill side
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    // Drain side
    output wire [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr;
    reg [AW-1:0]    rdPtr;
    reg [AW:0]      count;
    wire            doWr;
    wire            doRd;

    assign inReady  = (count != DEPTH[AW:0]);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    // Pointers and occupancy
    always @(posedge clk) begin
        if (sys_rst) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                mem[wrPtr] <= inData;
                wrPtr      <= wrPtr + 1'b1;
            end
            if (doRd)
                rdPtr <= rdPtr + 1'b1;
            if (doWr && !doRd)
                count <= count + 1'b1;
            else if (doRd && !doWr)
                count <= count - 1'b1;
        end
    end
endmodule

module spp_port #(
    parameter WIDTH = `SPP_WORD_BITS,
    parameter DIV   = `SPP_DIV_DEFAULT
) (
    // Clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // Configuration
    input  wire             masterMode,
    input  wire             clkPolarity,
    input  wire             clkPhase,
    // Transmit stream
    input  wire [WIDTH-1:0] txData,
    input  wire             txValid,
    output wire             txReady,
    // Receive stream and status
    output reg  [WIDTH-1:0] rxData,
    output reg              rxValid,
    output reg              busy,
    output reg              multiMasterError,
    input  wire             errorClear,
    // Pins
    input  wire             masterOutLineIn,
    output reg              masterOutLineOut,
    output reg              masterOutLineOe,
    input  wire             masterInLineIn,
    output reg              masterInLineOut,
    output reg              masterInLineOe,
    input  wire             shiftClockIn,
    output reg              shiftClockOut,
    output reg              shiftClockOe,
    input  wire             slaveSelectInputN
);
    localparam ST_IDLE = 2'd0;
    localparam ST_MRUN = 2'd1;
    localparam ST_SRUN = 2'd2;
    localparam CW      = `SPP_CNT_BITS;

    // Three-stage synchronisers for pin inputs
    reg [2:0]   sckSync;
    reg [2:0]   selSync;
    reg [2:0]   mosiSync;
    reg [2:0]   misoSync;
    reg         sckLvl;
    reg         selLvl;
    reg [1:0]   state;
    reg [WIDTH-1:0] shReg;
    reg [CW-1:0] bitCnt;
    reg [7:0]   divCnt;
    reg         edgeHalf;
    wire [WIDTH-1:0] fData;
    wire        fValid;
    reg         fTake;
    wire        sckRise;
    wire        sckFall;
    wire        selOn;
    wire        leadEdge;
    wire        trailEdge;
    wire        selAgree;
    wire        sckAgree;

    spp_fifo #(.WIDTH(WIDTH), .DEPTH(`SPP_FIFO_DEPTH), .AW(2)) uFifo (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inData   (txData),
        .inValid  (txValid),
        .inReady  (txReady),
        .outData  (fData),
        .outValid (fValid),
        .outReady (fTake)
    );

    // A change counts only once stages two and three agree
    assign sckAgree = (sckSync[1] == sckSync[2]);
    assign selAgree = (selSync[1] == selSync[2]);
    always @(posedge clk) begin
        if (sys_rst) begin
            sckSync <= 3'h0;
            selSync <= 3'h7;
            mosiSync <= 3'h0;
            misoSync <= 3'h0;
            sckLvl <= 1'b0;
            selLvl <= 1'b1;
        end else begin
            sckSync  <= {sckSync[1:0], shiftClockIn};
            selSync  <= {selSync[1:0], slaveSelectInputN};
            mosiSync <= {mosiSync[1:0], masterOutLineIn};
            misoSync <= {misoSync[1:0], masterInLineIn};
            if (sckAgree)
                sckLvl <= sckSync[2];
            if (selAgree)
                selLvl <= selSync[2];
        end
    end

    assign sckRise = sckAgree && sckSync[2] && !sckLvl;
    assign sckFall = sckAgree && !sckSync[2] && sckLvl;
    assign selOn   = !selLvl;
    // Leading edge leaves idle level; polarity picks which way
    assign leadEdge  = clkPolarity ? sckFall : sckRise;
    assign trailEdge = clkPolarity ? sckRise : sckFall;

    // Transfer engine for both modes
    always @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            shReg <= {WIDTH{1'b0}};
            bitCnt <= {CW{1'b0}};
            divCnt <= 8'h00;
            edgeHalf <= 1'b0;
            rxData <= {WIDTH{1'b0}};
            rxValid <= 1'b0;
            busy <= 1'b0;
            fTake <= 1'b0;
            multiMasterError <= 1'b0;
            masterOutLineOut <= 1'b0;
            masterOutLineOe <= 1'b0;
            masterInLineOut <= 1'b0;
            masterInLineOe <= 1'b0;
            shiftClockOut <= 1'b0;
            shiftClockOe <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            fTake <= 1'b0;
            // Set beats clear so a collision is never lost
            if (masterMode && selOn)
                multiMasterError <= 1'b1;
            else if (errorClear)
                multiMasterError <= 1'b0;
            // Pin directions follow mode
            shiftClockOe    <= masterMode;
            masterOutLineOe <= masterMode;
            masterInLineOe  <= !masterMode && selOn;
            case (state)
            ST_IDLE: begin
                busy <= 1'b0;
                shiftClockOut <= clkPolarity; // Idle level
                bitCnt <= {CW{1'b0}};
                edgeHalf <= 1'b0;
                divCnt <= 8'h00;
                if (masterMode && fValid && !fTake && !selOn) begin
                    shReg <= fData;
                    fTake <= 1'b1;
                    busy <= 1'b1;
                    masterOutLineOut <= fData[WIDTH-1];
                    state <= ST_MRUN;
                end else if (!masterMode && selOn) begin
                    // Slave word comes from FIFO or zeros when empty
                    shReg <= fValid ? fData : {WIDTH{1'b0}};
                    fTake <= fValid;
                    busy <= 1'b1;
                    masterInLineOut <= fValid ? fData[WIDTH-1] : 1'b0;
                    state <= ST_SRUN;
                end
            end
            ST_MRUN: begin
                // Abort on collision; clock goes back to idle, pins stay driven
                if (!masterMode || selOn) begin
                    state <= ST_IDLE;
                end else if (divCnt == DIV[7:0] - 8'h01) begin
                    divCnt <= 8'h00;
                    shiftClockOut <= !shiftClockOut;
                    edgeHalf <= !edgeHalf;
                    // Phase 0 samples first half, phase 1 second
                    if (edgeHalf == clkPhase) begin
                        shReg <= {shReg[WIDTH-2:0], misoSync[2]};
                        bitCnt <= bitCnt + 1'b1;
                    end else if (bitCnt != {CW{1'b0}} || clkPhase)
                        masterOutLineOut <= shReg[WIDTH-1];
                    // Phase 0 ends on the trailing edge after all samples
                    if (edgeHalf && bitCnt == WIDTH[CW-1:0]
                        && !clkPhase) begin
                        rxData <= shReg;
                        rxValid <= 1'b1;
                        state <= ST_IDLE;
                    end
                    if (edgeHalf && clkPhase
                        && bitCnt == WIDTH[CW-1:0] - 1'b1) begin
                        rxData <= {shReg[WIDTH-2:0], misoSync[2]};
                        rxValid <= 1'b1;
                        state <= ST_IDLE;
                    end
                end else
                    divCnt <= divCnt + 8'h01;
            end
            ST_SRUN: begin
                // Deselect ends the slave frame
                if (masterMode || !selOn) begin
                    state <= ST_IDLE;
                end else if (clkPhase ? trailEdge : leadEdge) begin
                    shReg <= {shReg[WIDTH-2:0], mosiSync[2]};
                    // Next bit leaves with the sample edge; waiting for
                    // the other edge adds a sync delay onto the sample
                    masterInLineOut <= shReg[WIDTH-2];
                    if (bitCnt == WIDTH[CW-1:0] - 1'b1) begin
                        rxData <= {shReg[WIDTH-2:0], mosiSync[2]};
                        rxValid <= 1'b1;
                        bitCnt <= {CW{1'b0}};
                        state <= ST_IDLE;
                    end else
                        bitCnt <= bitCnt + 1'b1;
                end
            end
            default: state <= ST_IDLE;
            endcase
        end
    end
    // Slave select of external parts is a software GPIO
endmodule

// >>> bench/spp_port_monitor.sv
// Checker of the serial port pins and status
`timescale 1ns/1ps
module spp_port_monitor (
    // Clock, reset, mode
    input wire clk, sys_rst, masterMode, clkPolarity,
    // Status and pins
    input wire rxValid, busy, multiMasterError, errorClear,
    input wire masterOutLineOe, masterInLineOe, shiftClockOut,
    input wire shiftClockOe, slaveSelectInputN
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_slv; !masterMode && !$past(masterMode) |->
        !shiftClockOe && !masterOutLineOe; endproperty
    a_slv: assert property (p_slv)
        else $error("slave drove a master pin");
    property p_mst; masterMode && $past(masterMode) |->
        !masterInLineOe; endproperty
    a_mst: assert property (p_mst)
        else $error("master drove its input line");
    // Idle level only checked once polarity has been steady
    property p_idle; (masterMode && !busy && $stable(clkPolarity))[*4]
        |-> shiftClockOut == clkPolarity; endproperty
    a_idle: assert property (p_idle)
        else $error("clock not idle between words");
    property p_err; (masterMode && !slaveSelectInputN)[*6]
        |-> multiMasterError; endproperty
    a_err: assert property (p_err)
        else $error("select in master mode not flagged");
    property p_keep; multiMasterError && !errorClear |=>
        multiMasterError; endproperty
    a_keep: assert property (p_keep)
        else $error("error flag lost without clear");
    property p_noerr; (!masterMode)[*6] |->
        !$rose(multiMasterError); endproperty
    a_noerr: assert property (p_noerr)
        else $error("error flag raised in slave mode");
    property p_done; masterMode && $rose(busy) |-> ##[1:100]
        (rxValid || !slaveSelectInputN || !masterMode); endproperty
    a_done: assert property (p_done)
        else $error("master word never completed");
    property p_desel; (!masterMode && slaveSelectInputN)[*6]
        |-> !masterInLineOe; endproperty
    a_desel: assert property (p_desel)
        else $error("unselected slave drove its line");
endmodule
bind spp_port spp_port_monitor u_mon (.*);

// >>> bench/spp_slave_model.sv
// Behavioural serial slave answering the port in master mode
`timescale 1ns/1ps
module spp_slave_model (
    // Pins; select comes from a general-purpose output
    input  wire       sck, mosi, selN, cpol, cpha,
    input  wire [7:0] reply,
    output reg        miso,
    output reg  [7:0] got
);
    reg [7:0] sh;
    wire act = sck ^ cpol; // High while the clock is away from idle
    // Next bit out, most significant first
    task put; begin miso = sh[7]; sh = sh << 1; end endtask
    initial begin miso = 1'b0; got = 8'h00; sh = 8'h00; end
    // Phase 0 needs the first bit before the first edge
    always @(negedge selN) begin sh = reply; if (!cpha) put; end
    // Released line must not keep a stale level
    always @(posedge selN) miso = ~miso;
    always @(posedge act) if (!selN) begin
        if (cpha) put; else got = {got[6:0], mosi};
    end
    always @(negedge act) if (!selN) begin
        if (cpha) got = {got[6:0], mosi}; else put;
    end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/1ps
module tb_top;
    // Design and partner inputs, bench pin drives and capture
    reg clk, sys_rst, masterMode, clkPolarity, clkPhase, txValid;
    reg errorClear, slaveSelectInputN, partSelN, bMosi, bSck;
    reg [7:0] txData, reply, r;
    // Design and partner outputs
    wire txReady, rxValid, busy, multiMasterError, modelMiso;
    wire masterOutLineOut, masterOutLineOe, masterInLineOut;
    wire masterInLineOe, shiftClockOut, shiftClockOe;
    wire [7:0] rxData, got;
    integer mismatches, total_checks, rxCount, i, k, m, b;
    // Wire levels from the port's enables, else bench or partner
    wire masterOutLineIn = masterOutLineOe ? masterOutLineOut : bMosi;
    wire masterInLineIn = masterInLineOe ? masterInLineOut : modelMiso;
    wire shiftClockIn = shiftClockOe ? shiftClockOut : bSck;
    spp_port u_dut (.*);
    spp_slave_model u_part (.sck(shiftClockIn), .mosi(masterOutLineIn),
        .selN(partSelN), .cpol(clkPolarity), .cpha(clkPhase),
        .reply(reply), .miso(modelMiso), .got(got));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Counting words, so a one-cycle pulse is never missed
    always @(posedge clk)
        if (sys_rst) rxCount <= 0;
        else if (rxValid === 1'b1) rxCount <= rxCount + 1;
    task tick(input integer n); repeat (n) @(posedge clk); endtask
    task chk(input [7:0] a, input [7:0] e); begin
        total_checks = total_checks + 1;
        if (a !== e) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: got %h want %h", $time, a, e);
        end
    end endtask
    task tally_and_finish; begin
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    end endtask
    // Bounded wait until n words have arrived
    task waitRx(input integer n); begin
        k = 0;
        while (rxCount < n && k < 400) begin tick(1); k = k + 1; end
        if (rxCount < n) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: word timeout", $time);
            tally_and_finish;
        end
    end endtask
    task pushN(input integer n, input [7:0] w); begin
        for (i = 0; i < n; i = i + 1) begin
            txData <= w + i[7:0];
            txValid <= 1'b1;
            tick(1);
        end
        txValid <= 1'b0;
    end endtask
    initial begin
        {sys_rst, masterMode, clkPolarity, clkPhase, txValid} = 5'h10;
        {errorClear, bMosi, bSck, slaveSelectInputN, partSelN} = 5'h03;
        {txData, reply, r} = 24'h0;
        {mismatches, total_checks} = 64'h0;
        tick(2);
        sys_rst <= 1'b0;
        masterMode <= 1'b1;
        tick(3);
        // Every clock mode as master against the partner
        for (m = 0; m < 4; m = m + 1) begin
            {clkPolarity, clkPhase} <= m[1:0];
            reply <= 8'h5a ^ m[7:0];
            tick(6);
            partSelN <= 1'b0;
            tick(1);
            pushN(1, 8'hc3 ^ m[7:0]);
            waitRx(m + 1);
            chk(rxData, 8'h5a ^ m[7:0]);
            chk(got, 8'hc3 ^ m[7:0]);
            tick(4);
            partSelN <= 1'b1;
            $display("master mode %0d done", m);
        end
        // Select low as master: flagged, no start, FIFO fills
        slaveSelectInputN <= 1'b0;
        // Let the select settle so that no word is started
        tick(6);
        pushN(4, 8'h10);
        tick(4);
        chk({7'h0, multiMasterError}, 8'h01);
        chk({6'h0, busy, txReady}, 8'h00);
        slaveSelectInputN <= 1'b1;
        partSelN <= 1'b0;
        tick(6);
        errorClear <= 1'b1;
        tick(1);
        errorClear <= 1'b0;
        waitRx(8);
        chk({7'h0, multiMasterError}, 8'h00);
        chk(got, 8'h13);
        partSelN <= 1'b1;
        $display("fill and error test done");
        // Slave frames from an outside master at 800 ns per bit
        masterMode <= 1'b0;
        for (m = 0; m < 4; m = m + 3) begin
            {clkPolarity, clkPhase} <= m[1:0];
            bSck <= m[1]; // Idle level before select
            reply <= 8'h3c ^ m[7:0];
            pushN(1, 8'ha5 ^ m[7:0]);
            tick(4);
            slaveSelectInputN <= 1'b0;
            tick(8);
            // Phase 1 opens each bit with the leading edge
            for (b = 0; b < 8; b = b + 1) begin
                bSck <= clkPolarity ^ clkPhase;
                bMosi <= reply[7 - b];
                tick(4);
                bSck <= !(clkPolarity ^ clkPhase);
                r = {r[6:0], masterInLineIn};
                tick(4);
            end
            chk({7'h0, masterInLineOe}, 8'h01);
            bSck <= clkPolarity;
            tick(4);
            slaveSelectInputN <= 1'b1;
            waitRx(9 + m / 3);
            chk(rxData, 8'h3c ^ m[7:0]);
            chk(r, 8'ha5 ^ m[7:0]);
            chk({7'h0, multiMasterError}, 8'h00);
            tick(6);
            $display("slave mode %0d done", m);
        end
        tally_and_finish;
    end
endmodule
